/* File: rtl/rlt_pkg.sv */
package rlt_pkg;

	// Reset values
	localparam logic [7:0]  RLT_COUNT_RST  = 8'h00;
	localparam logic [7:0]  RLT_RELOAD_RST = 8'h00;
	// Core clock prescaler: divide by 12
	localparam int          RLT_PRESCALE   = 12;
	localparam logic [3:0]  RLT_PRE_LAST   = 4'(RLT_PRESCALE - 1);
	// External oscillator divide by 8: edge counter phases
	localparam logic [2:0]  RLT_EXT_RISE   = 3'h3;
	localparam logic [2:0]  RLT_EXT_FALL   = 3'h7;
	// Wrap points
	localparam logic [7:0]  RLT_BYTE_MAX   = 8'hFF;
	localparam logic [15:0] RLT_WORD_MAX   = 16'hFFFF;

	// Mode and control bits, held by the owner of the control registers
	typedef struct packed {
		logic split_mode_select;
		logic high_run_control;
		logic low_byte_irq_enable;
		logic capture_enable;
		logic external_select;
		logic high_clock_select;
		logic low_clock_select;
		logic timer_irq_enable;
	} rlt_ctrl_s;

	// Software write strobes with one shared data byte
	typedef struct packed {
		logic       count_low_wr;
		logic       count_high_wr;
		logic       reload_low_wr;
		logic       reload_high_wr;
		logic       flags_wr;
		logic [7:0] data;
	} rlt_wr_s;

	// Flag write data bit positions
	localparam int RLT_FLAG_HIGH_BIT = 7;
	localparam int RLT_FLAG_LOW_BIT  = 6;

endpackage

/* File: rtl/rlt_timer.sv */
// What this block does
// - Two count bytes form one timer; split bit picks 16-bit or dual 8-bit.
// - Tick source is core clock, core clock over 12, or oscillator over 8.
// - Oscillator is synchronised to the core clock before it counts.
// - 16-bit wrap from FFFF loads the reload word and sets high flag.
// - 16-bit mode interrupts on every overflow when interrupts are enabled.
// - 16-bit mode also interrupts on low byte wrap when its enable is set.
// - Split mode: each byte reloads from its own reload byte on wrap.
// - Split mode: run bit gates only the high byte; low byte always runs.
// - Clock select 1 picks core clock; else external select picks source.
// - Split mode: each byte's wrap sets its own overflow flag.
// - Split mode interrupts on high wrap, or either wrap with low enable.
// - Flags stay set until software writes them to zero.
// - Capture mode: low byte (and so the 16-bit count) counts core clock or core clock over 12 only.
// - Capture copies the count into the reload bytes and sets high flag.
// - Capture event is each falling edge of oscillator over 8.
// - Capture enable bit 1 turns capture mode on, 0 turns it off.
`timescale 1ns/1ns
module rlt_timer
	import rlt_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       CLOCK_IN,
	input  wire logic       RST_B_IN,
	input  wire logic       CLK_EN_IN,
	// Control bits and software writes
	input  wire rlt_ctrl_s  CTRL_IN,
	input  wire rlt_wr_s    WR_IN,
	// External oscillator
	input  wire logic       EXT_OSC_IN,
	// State
	output logic [7:0]      COUNT_LOW_OUT,
	output logic [7:0]      COUNT_HIGH_OUT,
	output logic [7:0]      RELOAD_LOW_OUT,
	output logic [7:0]      RELOAD_HIGH_OUT,
	output logic            HIGH_OVERFLOW_FLAG_OUT,
	output logic            LOW_OVERFLOW_FLAG_OUT,
	output logic            IRQ_OUT
);

	logic       osc_meta_q;
	logic       osc_sync_q;
	logic       osc_prev_q;
	logic [2:0] ext_cnt_q;
	logic [3:0] pre_cnt_q;
	logic [7:0] cnt_l_q;
	logic [7:0] cnt_h_q;
	logic [7:0] rld_l_q;
	logic [7:0] rld_h_q;
	logic       flag_h_q;
	logic       flag_l_q;
	logic       irq_q;

	logic       osc_rise;
	logic       ext_tick;
	logic       cap_evt;
	logic       pre_tick;
	logic       src_tick;
	logic       tick_l;
	logic       tick_h;
	logic       inc_l;
	logic       inc_h;
	logic       wrap_l;
	logic       wrap_h;
	logic [7:0] cnt_l_d;
	logic [7:0] cnt_h_d;
	logic       flag_h_d;
	logic       flag_l_d;

	// Oscillator synchroniser and edge detect
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			osc_meta_q <= 1'b0;
			osc_sync_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end
		else if (CLK_EN_IN)
		begin
			osc_meta_q <= EXT_OSC_IN;
			osc_sync_q <= osc_meta_q;
			osc_prev_q <= osc_sync_q;
		end
	end

	assign osc_rise = osc_sync_q & ~osc_prev_q;

	// Divide by 8: bit 2 of the edge counter is the divided clock
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
			ext_cnt_q <= 3'h0;
		else if (CLK_EN_IN && osc_rise)
			ext_cnt_q <= ext_cnt_q + 3'h1;
	end

	assign ext_tick = osc_rise && (ext_cnt_q == RLT_EXT_RISE);
	assign cap_evt  = CTRL_IN.capture_enable && osc_rise
		&& (ext_cnt_q == RLT_EXT_FALL);

	// Core clock prescaler
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
			pre_cnt_q <= 4'h0;
		else if (CLK_EN_IN)
			pre_cnt_q <= pre_tick ? 4'h0 : pre_cnt_q + 4'h1;
	end

	assign pre_tick = (pre_cnt_q == RLT_PRE_LAST);

	// Tick selection per byte
	always_comb
	begin
		src_tick = CTRL_IN.external_select ? ext_tick : pre_tick;
		if (CTRL_IN.capture_enable)
			tick_l = CTRL_IN.low_clock_select | pre_tick;
		else
			tick_l = CTRL_IN.low_clock_select | src_tick;
		tick_h = CTRL_IN.high_clock_select | src_tick;
	end

	// Counting and auto-reload
	always_comb
	begin
		wrap_l   = 1'b0;
		wrap_h   = 1'b0;
		cnt_l_d  = cnt_l_q;
		cnt_h_d  = cnt_h_q;
		if (CTRL_IN.split_mode_select)
		begin
			inc_l = tick_l;
			inc_h = tick_h && CTRL_IN.high_run_control;
			if (inc_l)
			begin
				wrap_l  = (cnt_l_q == RLT_BYTE_MAX);
				cnt_l_d = wrap_l ? rld_l_q : cnt_l_q + 8'h01;
			end
			if (inc_h)
			begin
				wrap_h  = (cnt_h_q == RLT_BYTE_MAX);
				cnt_h_d = wrap_h ? rld_h_q : cnt_h_q + 8'h01;
			end
		end
		else
		begin
			inc_l = tick_l && CTRL_IN.high_run_control;
			inc_h = inc_l;
			if (inc_l)
			begin
				wrap_l = (cnt_l_q == RLT_BYTE_MAX);
				wrap_h = ({cnt_h_q, cnt_l_q} == RLT_WORD_MAX);
				{cnt_h_d, cnt_l_d} = wrap_h ? {rld_h_q, rld_l_q}
					: {cnt_h_q, cnt_l_q} + 16'h0001;
			end
		end
		if (WR_IN.count_low_wr)
			cnt_l_d = WR_IN.data;
		if (WR_IN.count_high_wr)
			cnt_h_d = WR_IN.data;
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			cnt_l_q <= RLT_COUNT_RST;
			cnt_h_q <= RLT_COUNT_RST;
		end
		else if (CLK_EN_IN)
		begin
			cnt_l_q <= cnt_l_d;
			cnt_h_q <= cnt_h_d;
		end
	end

	// Reload bytes; capture wins over software
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			rld_l_q <= RLT_RELOAD_RST;
			rld_h_q <= RLT_RELOAD_RST;
		end
		else if (CLK_EN_IN)
		begin
			if (cap_evt)
			begin
				rld_l_q <= cnt_l_q;
				rld_h_q <= cnt_h_q;
			end
			else
			begin
				if (WR_IN.reload_low_wr)
					rld_l_q <= WR_IN.data;
				if (WR_IN.reload_high_wr)
					rld_h_q <= WR_IN.data;
			end
		end
	end

	// Sticky flags: hardware set beats software clear
	always_comb
	begin
		flag_h_d = flag_h_q;
		flag_l_d = flag_l_q;
		if (WR_IN.flags_wr)
		begin
			flag_h_d = WR_IN.data[RLT_FLAG_HIGH_BIT];
			flag_l_d = WR_IN.data[RLT_FLAG_LOW_BIT];
		end
		if (wrap_h || cap_evt)
			flag_h_d = 1'b1;
		if (wrap_l)
			flag_l_d = 1'b1;
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
		begin
			flag_h_q <= 1'b0;
			flag_l_q <= 1'b0;
		end
		else if (CLK_EN_IN)
		begin
			flag_h_q <= flag_h_d;
			flag_l_q <= flag_l_d;
		end
	end

	// Interrupt request level
	always_ff @(posedge CLOCK_IN)
	begin
		if (!RST_B_IN)
			irq_q <= 1'b0;
		else if (CLK_EN_IN)
			irq_q <= CTRL_IN.timer_irq_enable && (flag_h_d
				|| (CTRL_IN.low_byte_irq_enable && flag_l_d));
	end

	assign COUNT_LOW_OUT          = cnt_l_q;
	assign COUNT_HIGH_OUT         = cnt_h_q;
	assign RELOAD_LOW_OUT         = rld_l_q;
	assign RELOAD_HIGH_OUT        = rld_h_q;
	assign HIGH_OVERFLOW_FLAG_OUT = flag_h_q;
	assign LOW_OVERFLOW_FLAG_OUT  = flag_l_q;
	assign IRQ_OUT                = irq_q;

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_B_IN || !CLK_EN_IN);

	logic no_wr;
	assign no_wr = !(WR_IN.count_low_wr || WR_IN.count_high_wr
		|| WR_IN.reload_low_wr || WR_IN.reload_high_wr || WR_IN.flags_wr);

	sequence s_capture;
		cap_evt && no_wr;
	endsequence

	a_word_wrap_reload: assert property (
		!CTRL_IN.split_mode_select && inc_l && no_wr
		&& {cnt_h_q, cnt_l_q} == RLT_WORD_MAX
		|=> {cnt_h_q, cnt_l_q} == $past({rld_h_q, rld_l_q}) && flag_h_q)
		else $error("16-bit wrap did not reload or flag");
	a_word_hold_stop: assert property (
		!CTRL_IN.split_mode_select && !CTRL_IN.high_run_control && no_wr
		|=> $stable({cnt_h_q, cnt_l_q}))
		else $error("16-bit count moved while stopped");
	a_split_high_hold: assert property (
		CTRL_IN.split_mode_select && !CTRL_IN.high_run_control && no_wr
		|=> $stable(cnt_h_q))
		else $error("high byte moved while stopped");
	a_split_low_runs: assert property (
		CTRL_IN.split_mode_select && CTRL_IN.low_clock_select && no_wr
		&& !CTRL_IN.capture_enable
		|=> cnt_l_q == (($past(cnt_l_q) == RLT_BYTE_MAX) ? $past(rld_l_q)
			: $past(cnt_l_q) + 8'h01))
		else $error("low byte did not advance in split mode");
	a_flag_sticky: assert property (
		flag_h_q && no_wr |=> flag_h_q)
		else $error("high flag cleared without a write");
	a_capture_copy: assert property (
		s_capture |=> {rld_h_q, rld_l_q} == $past({cnt_h_q, cnt_l_q})
		&& flag_h_q)
		else $error("capture did not copy count");
	a_prescale_gap: assert property (
		pre_tick |=> !pre_tick [*8] ##1 !pre_tick [*3] ##1 pre_tick)
		else $error("prescaler period is not 12");
	a_irq_follows: assert property (
		CTRL_IN.timer_irq_enable && wrap_h |=> IRQ_OUT)
		else $error("overflow raised no interrupt");
	a_irq_masked: assert property (
		!CTRL_IN.timer_irq_enable |=> !IRQ_OUT)
		else $error("interrupt raised while disabled");

endmodule

/* File: verif/rlt_osc_model.sv */
`timescale 1ns/1ns
module rlt_osc_model
#(
	parameter int HALF_NS  = 36,
	parameter int PHASE_NS = 2
)
(
	input  wire logic run_in,
	output logic      osc_out
);
	// Free-running source, parked low when stopped
	initial
	begin
		osc_out = 1'b0;
		// Keep edges clear of the core clock edges
		#PHASE_NS;
		forever
		begin
			#HALF_NS;
			osc_out = run_in ? ~osc_out : 1'b0;
		end
	end
endmodule

/* File: verif/reload_timer_with_osc_capture_tb.sv */
`timescale 1ns/1ns
module reload_timer_with_osc_capture_tb import rlt_pkg::*;;
	logic        clk, rst_b, clk_en, osc_run, osc;
	rlt_ctrl_s   ctrl;
	rlt_wr_s     wr;
	logic [7:0]  cl, ch, rl, rh;
	logic        hf, lf, irq;
	logic [31:0] lfsr;
	logic [15:0] r;
	int          err_count, checked, cyc, i;
	// Core clock cycles per oscillator period
	localparam int OSC_CYC = 9;

	rlt_timer uut
	(
		.CLOCK_IN               (clk),
		.RST_B_IN               (rst_b),
		.CLK_EN_IN              (clk_en),
		.CTRL_IN                (ctrl),
		.WR_IN                  (wr),
		.EXT_OSC_IN             (osc),
		.COUNT_LOW_OUT          (cl),
		.COUNT_HIGH_OUT         (ch),
		.RELOAD_LOW_OUT         (rl),
		.RELOAD_HIGH_OUT        (rh),
		.HIGH_OVERFLOW_FLAG_OUT (hf),
		.LOW_OVERFLOW_FLAG_OUT  (lf),
		.IRQ_OUT                (irq)
	);

	rlt_osc_model
	#(
		.HALF_NS (4 * OSC_CYC)
	)
	osc_m
	(
		.run_in  (osc_run),
		.osc_out (osc)
	);

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], ^(s & 32'h80200003)};
	endfunction

	// Ticks expected in n core cycles with a divider of d
	function automatic logic [15:0] ticks(input int n, input int d);
		return 16'(n / d);
	endfunction

	task automatic wrap_up();
		$display("Checks %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// sel: 0/1 count, 2/3 reload, 4 flags
	task automatic put(input int sel, input logic [7:0] d);
		@(negedge clk);
		wr = {5'(5'h10 >> sel), d};
		@(negedge clk);
		wr = '0;
	endtask

	task automatic setw(input int base, input logic [15:0] v);
		put(base, v[7:0]);
		put(base + 1, v[15:8]);
	endtask

	task automatic wait_hf();
		int k;
		k = 0;
		while (hf !== 1'b1 && k < 200)
		begin
			@(negedge clk);
			k++;
		end
		chk({15'h0000, hf}, 16'h0001);
	endtask

	// Gap between two captures, in count ticks
	task automatic cap_gap(input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] a;
		ctrl = c;
		put(4, 8'h00);
		wait_hf();
		a = {rh, rl};
		put(4, 8'h00);
		wait_hf();
		chk({rh, rl} - a, exp);
	endtask

	initial
	begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_count++;
			wrap_up();
		end
	end

	initial
	begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		osc_run = 1'b0;
		ctrl = 8'h02;
		wr = '0;
		lfsr = 32'h000120D0;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		chk({ch, cl}, 16'h0000);
		chk({rh, rl}, 16'h0000);
		chk({13'h0000, hf, lf, irq}, 16'h0000);
		osc_run = 1'b1;
		for (i = 0; i < 4; i++)
		begin
			lfsr = nx(lfsr);
			setw(2 * (i % 2), lfsr[15:0]);
			chk((i % 2) ? {rh, rl} : {ch, cl}, lfsr[15:0]);
		end
		lfsr = nx(lfsr);
		r = lfsr[15:0];
		ctrl = 8'h03;
		setw(2, r);
		setw(0, 16'hFFFF);
		ctrl = 8'h43;
		@(negedge clk);
		ctrl = 8'h03;
		chk({ch, cl}, r);
		chk({14'h0000, hf, irq}, 16'h0003);
		repeat (5) @(negedge clk);
		chk({ch, cl}, r);
		chk({15'h0000, hf}, 16'h0001);
		put(4, 8'h00);
		@(negedge clk);
		chk({14'h0000, hf, irq}, 16'h0000);
		for (i = 0; i < 2; i++)
		begin
			put(4, 8'h00);
			setw(0, 16'h00FF);
			ctrl = i ? 8'h63 : 8'h43;
			@(negedge clk);
			ctrl = 8'h03;
			chk({ch, cl}, 16'h0100);
			chk({13'h0000, hf, lf, irq}, {14'h0000, 1'b1, 1'(i)});
		end
		for (i = 0; i < 2; i++)
		begin
			put(4, 8'h00);
			lfsr = nx(lfsr);
			r = lfsr[15:0] & 16'hFFFE;
			setw(2, r);
			setw(0, 16'hFFFF);
			ctrl = i ? 8'hA7 : 8'h87;
			@(negedge clk);
			chk({ch, cl}, {8'hFF, r[7:0]});
			chk({13'h0000, hf, lf, irq}, {14'h0000, 1'b1, 1'(i)});
			ctrl = i ? 8'hE7 : 8'hC7;
			@(negedge clk);
			ctrl = 8'h03;
			chk({ch, cl}, {r[15:8], r[7:0] + 8'h01});
			chk({14'h0000, hf, irq}, 16'h0003);
		end
		setw(0, 16'h0000);
		ctrl = 8'h41;
		repeat (12) @(negedge clk);
		// Clock enable low must freeze count and prescaler
		clk_en = 1'b0;
		repeat (30) @(negedge clk);
		chk({ch, cl}, ticks(12, RLT_PRESCALE));
		clk_en = 1'b1;
		repeat (12) @(negedge clk);
		ctrl = 8'h01;
		chk({ch, cl}, ticks(24, RLT_PRESCALE));
		setw(0, 16'h0000);
		ctrl = 8'h49;
		repeat (144) @(negedge clk);
		ctrl = 8'h09;
		chk({ch, cl}, ticks(144, 8 * OSC_CYC));
		setw(0, 16'h0000);
		cap_gap(8'h52, ticks(8 * OSC_CYC, 1));
		cap_gap(8'h58, ticks(8 * OSC_CYC, RLT_PRESCALE));
		ctrl = 8'h42;
		setw(2, 16'h5A5A);
		put(4, 8'h00);
		repeat (100) @(negedge clk);
		chk({rh, rl}, 16'h5A5A);
		chk({15'h0000, hf}, 16'h0000);
		// Reset again in mid-run while counting
		rst_b = 1'b0;
		@(negedge clk);
		rst_b = 1'b1;
		chk({ch, cl}, 16'h0000);
		chk({rh, rl}, 16'h0000);
		chk({13'h0000, hf, lf, irq}, 16'h0000);
		repeat (2) @(negedge clk);
		chk({ch, cl}, 16'h0002);
		wrap_up();
	end
endmodule
